// file: hw/status_fault_defines.svh
// Constants of the status and fault report register set.
// Assumes inclusion by the package and by the register module.
// Operation
// RULE1: A protection action sets its latched fault bit: overvoltage 0, delayed limit 1, overheat 2, limit 6.
// RULE2: A latched fault bit stays set until the fault read query reads it, and that read clears it.
// RULE3: Fault mask bit 0 lets the latched overvoltage bit reach the fault summary.
// RULE4: Fault mask bit 1 lets the latched delayed-limit bit reach the fault summary.
// RULE5: Fault mask bits 2 and 6 let the latched overheat and limit bits reach the fault summary.
// RULE6: The controller writes zero to fault mask bits 3, 4, 5 and 7.
// RULE7: Mode bit 1 reads one when the crowbar option is fitted.
// RULE8: Mode bit 2 reads one while the external on/off input commands output off.
// RULE9: Mode bits 7 and 6 give the remote source: 00 local, 01 connector, 11 coaxial, 10 both.
// RULE10: Each error overwrites the error register, and the error query, clear command or device clear empty it.
// RULE11: The service request enable uses bits 0, 2, 3 and 4, and a request rises only for an enabled set status bit.
// RULE12: The live fault status shows the present unlatched conditions at the latched bit positions.
`ifndef STATUS_FAULT_DEFINES_SVH
`define STATUS_FAULT_DEFINES_SVH

`define FLT_OVERVOLTAGE_BIT 0
`define FLT_DELAYED_LIMIT_BIT 1
`define FLT_OVERHEAT_BIT 2
`define FLT_LIMIT_BIT 6
`define FLT_USED_MASK 8'h47

`define STB_FAULT_SUMMARY_BIT 0
`define STB_SEQUENCE_END_BIT 2
`define STB_ERROR_BIT 3
`define STB_SLAVE_BUS_BIT 4
`define SRE_USED_MASK 8'h1D

`define MODE_FAST_BIT 0
`define MODE_CROWBAR_BIT 1
`define MODE_EXT_OFF_BIT 2
`define MODE_VOLTAGE_REG_BIT 3
`define MODE_REMOTE_LO_BIT 6
`define MODE_REMOTE_HI_BIT 7

`define REG_RESET_VALUE 8'h00
`define ERR_NONE 8'h00

`define OP_READ_SRE 4'h0
`define OP_WRITE_SRE 4'h1
`define OP_READ_FAULTS 4'h2
`define OP_WRITE_FAULT_MASK 4'h3
`define OP_READ_FAULT_MASK 4'h4
`define OP_READ_LIVE 4'h5
`define OP_READ_MODE 4'h6
`define OP_READ_ERROR 4'h7
`define OP_CLEAR 4'h8
`define OP_DEVICE_CLEAR 4'h9

`endif

// file: hw/status_fault_pkg.sv
// Types of the status and fault report register set.
// Assumes the constants header is on the include path.
`include "status_fault_defines.svh"

package status_fault_pkg;

    typedef enum logic [3:0] {
        OP_READ_SRE = `OP_READ_SRE,
        OP_WRITE_SRE = `OP_WRITE_SRE,
        OP_READ_FAULTS = `OP_READ_FAULTS,
        OP_WRITE_FAULT_MASK = `OP_WRITE_FAULT_MASK,
        OP_READ_FAULT_MASK = `OP_READ_FAULT_MASK,
        OP_READ_LIVE = `OP_READ_LIVE,
        OP_READ_MODE = `OP_READ_MODE,
        OP_READ_ERROR = `OP_READ_ERROR,
        OP_CLEAR = `OP_CLEAR,
        OP_DEVICE_CLEAR = `OP_DEVICE_CLEAR
    } cmd_op_t;

    typedef struct packed {
        cmd_op_t op;
        logic [7:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic limit_trip;
        logic overheat_trip;
        logic delayed_limit_trip;
        logic overvoltage_trip;
    } fault_pins_t;

    typedef struct packed {
        logic remote_j2;
        logic remote_coax;
        logic voltage_regulation;
        logic external_output_off;
        logic crowbar_fitted;
        logic fast_response_sel;
    } mode_pins_t;

endpackage

// file: hw/status_fault_report_regs.sv
// Status, fault and mode report registers behind the remote command decoder.
// Assumes one command per valid cycle from same-clock logic; fault and mode pins are asynchronous.
`timescale 1ns/1ns
`include "status_fault_defines.svh"

module status_fault_report_regs
    import status_fault_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire cmd_req_t cmd_i,
    input wire fault_pins_t fault_pins_i,
    input wire mode_pins_t mode_pins_i,
    input wire logic error_valid_i,
    input wire logic [7:0] error_code_i,
    input wire logic sequence_end_i,
    input wire logic slave_bus_request_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic [7:0] status_byte_o,
    output logic service_request_o
);

    // Two-flop synchronisers; first stage feeds only the second
    fault_pins_t fault_meta_q;
    fault_pins_t fault_sync_q;
    mode_pins_t mode_meta_q;
    mode_pins_t mode_sync_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            fault_meta_q <= '0;
            fault_sync_q <= '0;
            mode_meta_q <= '0;
            mode_sync_q <= '0;
        end else begin
            fault_meta_q <= fault_pins_i;
            fault_sync_q <= fault_meta_q;
            mode_meta_q <= mode_pins_i;
            mode_sync_q <= mode_meta_q;
        end
    end

    logic [7:0] sre_q;
    logic [7:0] sre_d;
    logic [7:0] fault_mask_q;
    logic [7:0] fault_mask_d;
    logic [7:0] latched_q;
    logic [7:0] latched_d;
    logic [7:0] error_q;
    logic [7:0] error_d;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic [7:0] rsp_data_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic srq_q;

    // Command decode
    wire is_read_sre = cmd_valid_i && (cmd_i.op == OP_READ_SRE);
    wire wr_sre = cmd_valid_i && (cmd_i.op == OP_WRITE_SRE);
    wire rd_faults = cmd_valid_i && (cmd_i.op == OP_READ_FAULTS);
    wire wr_fault_mask = cmd_valid_i && (cmd_i.op == OP_WRITE_FAULT_MASK);
    wire rd_fault_mask = cmd_valid_i && (cmd_i.op == OP_READ_FAULT_MASK);
    wire rd_live = cmd_valid_i && (cmd_i.op == OP_READ_LIVE);
    wire rd_mode = cmd_valid_i && (cmd_i.op == OP_READ_MODE);
    wire rd_error = cmd_valid_i && (cmd_i.op == OP_READ_ERROR);
    wire clr_cmd = cmd_valid_i && (cmd_i.op == OP_CLEAR);
    wire dev_clr = cmd_valid_i && (cmd_i.op == OP_DEVICE_CLEAR);

    // RULE12: live conditions, unlatched
    wire [7:0] live_faults = {1'b0, fault_sync_q.limit_trip, 3'b000,
                              fault_sync_q.overheat_trip, fault_sync_q.delayed_limit_trip,
                              fault_sync_q.overvoltage_trip};

    // RULE1: protection actions set latched bits; set wins over the read clear
    // RULE2: only the fault read query clears
    assign latched_d = (rd_faults ? 8'h00 : latched_q) | live_faults;

    // RULE6: unused mask positions are dropped anyway, so a careless write is harmless
    assign fault_mask_d = wr_fault_mask ? (cmd_i.data & `FLT_USED_MASK) : fault_mask_q;
    // RULE11: only the four used enable positions are stored
    assign sre_d = wr_sre ? (cmd_i.data & `SRE_USED_MASK) : sre_q;

    // RULE3: overvoltage gated by mask bit 0
    wire en_ov = latched_q[`FLT_OVERVOLTAGE_BIT] & fault_mask_q[`FLT_OVERVOLTAGE_BIT];
    // RULE4: delayed limit gated by mask bit 1
    wire en_dl = latched_q[`FLT_DELAYED_LIMIT_BIT] & fault_mask_q[`FLT_DELAYED_LIMIT_BIT];
    // RULE5: overheat and limit gated by bits 2 and 6
    wire en_oh = latched_q[`FLT_OVERHEAT_BIT] & fault_mask_q[`FLT_OVERHEAT_BIT];
    wire en_lim = latched_q[`FLT_LIMIT_BIT] & fault_mask_q[`FLT_LIMIT_BIT];
    wire fault_summary = en_ov | en_dl | en_oh | en_lim;

    // RULE10: newest error overwrites; a new error beats a same-cycle clear
    wire err_clear = rd_error | clr_cmd | dev_clr;
    assign error_d = error_valid_i ? error_code_i : (err_clear ? `ERR_NONE : error_q);

    // RULE9: remote source code from the two source inputs
    wire remote_hi = mode_sync_q.remote_coax;
    wire remote_lo = mode_sync_q.remote_j2 ^ mode_sync_q.remote_coax;
    // RULE7: crowbar bit; RULE8: external off bit
    wire [7:0] mode_word = {remote_hi, remote_lo, 2'b00,
                            mode_sync_q.voltage_regulation,
                            mode_sync_q.external_output_off,
                            mode_sync_q.crowbar_fitted,
                            mode_sync_q.fast_response_sel};

    always_comb begin
        status_d = 8'h00;
        status_d[`STB_FAULT_SUMMARY_BIT] = fault_summary;
        status_d[`STB_SEQUENCE_END_BIT] = sequence_end_i;
        status_d[`STB_ERROR_BIT] = (error_q != `ERR_NONE);
        status_d[`STB_SLAVE_BUS_BIT] = slave_bus_request_i;
    end

    // Reads return the value before any clear of the same cycle
    assign rsp_data_d = is_read_sre ? sre_q :
                        rd_faults ? latched_q :
                        rd_fault_mask ? fault_mask_q :
                        rd_live ? live_faults :
                        rd_mode ? mode_word :
                        rd_error ? error_q : 8'h00;
    wire is_read = is_read_sre | rd_faults | rd_fault_mask | rd_live | rd_mode | rd_error;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sre_q <= `REG_RESET_VALUE;
            fault_mask_q <= `REG_RESET_VALUE;
            latched_q <= `REG_RESET_VALUE;
            error_q <= `ERR_NONE;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            status_q <= 8'h00;
            srq_q <= 1'b0;
        end else begin
            sre_q <= sre_d;
            fault_mask_q <= fault_mask_d;
            latched_q <= latched_d;
            error_q <= error_d;
            rsp_valid_q <= is_read;
            rsp_data_q <= rsp_data_d;
            status_q <= status_d;
            // RULE11: request only for an enabled set status bit
            srq_q <= |(status_d & sre_q);
        end
    end

    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;
    assign status_byte_o = status_q;
    assign service_request_o = srq_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_latch_sets_bit: assert property ( // RULE1
        fault_sync_q.overheat_trip |=> latched_q[`FLT_OVERHEAT_BIT])
        else $error("overheat condition not latched");
    a_latch_holds_bit: assert property ( // RULE2
        latched_q[`FLT_LIMIT_BIT] && !rd_faults |=> latched_q[`FLT_LIMIT_BIT])
        else $error("latched limit bit lost without fault read");
    a_read_clears_bit: assert property ( // RULE2
        rd_faults && !fault_sync_q.overvoltage_trip |=> !latched_q[`FLT_OVERVOLTAGE_BIT])
        else $error("fault read did not clear overvoltage bit");
    a_mask_ov_summary: assert property ( // RULE3
        en_ov |=> status_q[`STB_FAULT_SUMMARY_BIT])
        else $error("enabled overvoltage missing from summary");
    a_mask_dl_summary: assert property ( // RULE4
        latched_q[1] && !fault_mask_q[1] && !en_ov && !en_oh && !en_lim
        |=> !status_q[`STB_FAULT_SUMMARY_BIT])
        else $error("masked delayed limit reached summary");
    a_mask_oh_lim: assert property ( // RULE5
        (en_oh || en_lim) |=> status_q[`STB_FAULT_SUMMARY_BIT])
        else $error("enabled overheat or limit missing from summary");
    a_mask_unused_zero: assert property ( // RULE6
        (fault_mask_q & ~`FLT_USED_MASK) == 8'h00)
        else $error("unused fault mask bit set");
    a_mode_crowbar: assert property ( // RULE7
        rd_mode ##1 1'b1 |-> rsp_data_q[`MODE_CROWBAR_BIT] == $past(mode_sync_q.crowbar_fitted))
        else $error("crowbar bit wrong in mode read");
    a_mode_ext_off: assert property ( // RULE8
        rd_mode ##1 1'b1 |-> rsp_data_q[`MODE_EXT_OFF_BIT] == $past(mode_sync_q.external_output_off))
        else $error("external off bit wrong in mode read");
    a_remote_code_both: assert property ( // RULE9
        rd_mode && mode_sync_q.remote_j2 && mode_sync_q.remote_coax
        |=> rsp_data_q[7:6] == 2'b10)
        else $error("both sources not coded as 10");
    a_error_overwrite: assert property ( // RULE10
        error_valid_i |=> error_q == $past(error_code_i))
        else $error("error register not overwritten");
    a_error_clear: assert property ( // RULE10
        err_clear && !error_valid_i |=> error_q == `ERR_NONE)
        else $error("error register not emptied");
    a_srq_gating: assert property ( // RULE11
        sre_q == 8'h00 && $stable(sre_q) |=> !service_request_o)
        else $error("service request with empty enable");
    a_live_tracks: assert property ( // RULE12
        rd_live |=> rsp_data_q[`FLT_LIMIT_BIT] == $past(fault_sync_q.limit_trip))
        else $error("live status disagrees with condition");

    c_fault_latch_read: cover property (rd_faults && latched_q != 8'h00);
    c_srq_raised: cover property (!service_request_o ##1 service_request_o);
    c_error_cleared: cover property (error_q != `ERR_NONE ##1 error_q == `ERR_NONE);
    c_mode_read_coax: cover property (rd_mode && mode_sync_q.remote_coax);

endmodule

// file: verification/remote_ctrl_model.sv
// Remote controller model: one command at a time on the command port.
// Assumes reads answer at the taking edge itself, on the same clock.
`timescale 1ns/1ns

module remote_ctrl_model
    import status_fault_pkg::*;
(
    input wire logic clk_i,
    output logic cmd_valid_o,
    output cmd_req_t cmd_o,
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_data_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end

    task automatic issue(input cmd_op_t op, input logic [7:0] data,
        output logic [7:0] rdata, output logic answered);
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o.op = op;
        cmd_o.data = (op == OP_WRITE_FAULT_MASK) ? (data & 8'h47) : data;
        @(posedge clk_i);
        #1;
        answered = rsp_valid_i;
        rdata = rsp_data_i;
        cmd_valid_o = 1'b0;
        // Stale data scrambled so it is never mistaken for a request
        cmd_o.data = ~cmd_o.data;
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the status and fault report registers.
// Assumes the controller model owns the command port; the bench drives pins and errors.
`timescale 1ns/1ns

module tb_top;
    import status_fault_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid;
    cmd_req_t cmd;
    fault_pins_t fpins = '0;
    mode_pins_t mpins = '0;
    logic err_v = 1'b0;
    logic [7:0] err_c = 8'h00;
    logic seq_end = 1'b0;
    logic slave_req = 1'b0;
    logic rsp_v, srq, ans;
    logic [7:0] rsp_d, stb, got, m, e;
    integer failures = 0;
    integer checks_done = 0;
    integer seed = 50636;
    int pos[4] = '{0, 1, 2, 6};
    cmd_op_t rops[6] = '{OP_READ_SRE, OP_READ_FAULTS, OP_READ_FAULT_MASK,
        OP_READ_LIVE, OP_READ_MODE, OP_READ_ERROR};
    cmd_op_t clr[3] = '{OP_READ_ERROR, OP_CLEAR, OP_DEVICE_CLEAR};

    status_fault_report_regs status_fault_report_regs_i (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .fault_pins_i(fpins),
        .mode_pins_i(mpins), .error_valid_i(err_v), .error_code_i(err_c),
        .sequence_end_i(seq_end), .slave_bus_request_i(slave_req), .rsp_valid_o(rsp_v),
        .rsp_data_o(rsp_d), .status_byte_o(stb), .service_request_o(srq));
    remote_ctrl_model remote_ctrl_model_i (.clk_i(core_clk_i), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd), .rsp_valid_i(rsp_v), .rsp_data_i(rsp_d));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checks_done++;
        if (act !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic chk1(input logic a, input logic b);
        chk({7'h00, a}, {7'h00, b});
    endtask
    task automatic rd(input cmd_op_t op, input logic [7:0] exp);
        remote_ctrl_model_i.issue(op, 8'h00, got, ans);
        chk1(ans, 1'b1);
        chk(got, exp);
    endtask
    task automatic wr(input cmd_op_t op, input logic [7:0] d);
        remote_ctrl_model_i.issue(op, d, got, ans);
        chk1(ans, 1'b0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // Remote source code taken from the code table, not from the decode logic
    function automatic logic [7:0] mode_exp(input mode_pins_t p);
        logic [1:0] code;
        if (p.remote_j2 && p.remote_coax) begin
            code = 2'b10;
        end else if (p.remote_coax) begin
            code = 2'b11;
        end else if (p.remote_j2) begin
            code = 2'b01;
        end else begin
            code = 2'b00;
        end
        return {code, 2'b00, p.voltage_regulation,
            p.external_output_off, p.crowbar_fitted, p.fast_response_sel};
    endfunction
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        tick(2);
        rst_n_i = 1'b1;
        chk(stb, 8'h00);
        foreach (rops[i]) rd(rops[i], 8'h00);
        $display("reset test done");
        for (int k = 0; k < 6; k++) begin
            m = (k == 0) ? 8'hFF : 8'($random(seed));
            wr(OP_WRITE_SRE, m);
            rd(OP_READ_SRE, m & 8'h1D);
            wr(OP_WRITE_FAULT_MASK, m);
            rd(OP_READ_FAULT_MASK, m & 8'h47);
        end
        wr(cmd_op_t'(4'hF), 8'h00);
        $display("mask test done");
        wr(OP_WRITE_SRE, 8'h01);
        for (int k = 0; k < 8; k++) begin
            e = 8'h01 << pos[k % 4];
            wr(OP_WRITE_FAULT_MASK, (k < 4) ? e : (8'h47 & ~e));
            fpins = fault_pins_t'({e[6], e[2:0]});
            tick(6);
            rd(OP_READ_LIVE, e);
            chk1(stb[0], k < 4);
            chk1(srq, k < 4);
            fpins = '0;
            tick(6);
            rd(OP_READ_LIVE, 8'h00);
            chk1(stb[0], k < 4);
            rd(OP_READ_FAULTS, e);
            tick(2);
            rd(OP_READ_FAULTS, 8'h00);
            chk(stb, 8'h00);
        end
        $display("fault test done");
        foreach (clr[k]) begin
            wr(OP_WRITE_SRE, 8'h08);
            m = 8'($random(seed)) | 8'h01;
            err_v = 1'b1;
            err_c = 8'h21;
            tick(1);
            err_c = m;
            tick(1);
            err_v = 1'b0;
            tick(3);
            chk1(stb[3], 1'b1);
            chk1(srq, 1'b1);
            if (k == 0) begin
                rd(OP_READ_ERROR, m);
            end else begin
                wr(clr[k], 8'h00);
            end
            tick(2);
            rd(OP_READ_ERROR, 8'h00);
            chk(stb, 8'h00);
        end
        $display("error test done");
        for (int k = 0; k < 8; k++) begin
            m = 8'($random(seed));
            wr(OP_WRITE_SRE, m);
            seq_end = m[7];
            slave_req = m[5];
            tick(3);
            e = {3'b000, m[5], 1'b0, m[7], 2'b00};
            chk(stb, e);
            chk1(srq, |(e & m));
        end
        seq_end = 1'b0;
        slave_req = 1'b0;
        $display("status test done");
        for (int k = 0; k < 12; k++) begin
            mpins = mode_pins_t'(6'((k < 4) ? {k[1:0], 4'h0} : $random(seed)));
            tick(5);
            rd(OP_READ_MODE, mode_exp(mpins));
        end
        $display("mode test done");
        summarize();
    end

    // Run needs a few hundred cycles; this allows ample margin
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule
